// >>> hw/spm_top.sv
// Purpose: Four-mode serial port with AXI4-Lite registers
// Assumes: timer_ovf_in is a one-cycle pulse on core_clk_in
// Notes:   Writes to the buffer are ignored while mode 0 is busy
`timescale 1ns/1ps
module spm_top
    import spm_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        timer_ovf_in,
    input  wire logic        rxd_in,
    output logic             rxd_out,
    output logic             rxd_oe_n_out,
    output logic             txd_out,
    output logic             irq_out,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    output logic [1:0]       s_axi_bresp_out,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    input  wire logic [7:0]  s_axi_araddr_in,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out
);
    typedef struct packed {
        logic [1:0]  mode;
        logic        rmp;
        logic        ren;
        logic        tb8;
        logic        rb8;
        logic        rate_doubler_bit;
        logic [7:0]  own_addr;
        logic [7:0]  addr_mask;
        logic [7:0]  rbuf;
        logic        ri;
        logic        ti;
        logic        fe;
        logic [2:0]  imask;
        logic        irq;
        logic        m0_act;
        logic        m0_rx;
        logic [3:0]  m0_cnt;
        logic [3:0]  m0_bits;
        logic [7:0]  m0_sh;
        logic        txd;
        logic        dout;
        logic        doe_n;
        logic [1:0]  pdiv;
        logic        ovf_half;
        logic        tx_pend;
        logic        tx_act;
        logic [3:0]  tx_bits;
        logic [3:0]  tx_div;
        logic [10:0] tx_fr;
        logic        rx_act;
        logic        rx_prev;
        logic [3:0]  rx_div;
        logic [3:0]  rx_bits;
        logic [2:0]  rx_v;
        logic [9:0]  rx_sh;
        logic        awrdy;
        logic        wrdy;
        logic        arrdy;
        logic        bvalid;
        logic        rvalid;
        logic [1:0]  bresp;
        logic [1:0]  rresp;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        aw_got;
        logic        w_got;
        logic [31:0] rdata;
    } spm_top_s;

    spm_top_s   q;
    spm_top_s   d;
    logic       pin;
    logic [3:0] m0_div;
    logic [3:0] m0_half;
    logic       m0_wrap;
    logic       m0_last;
    logic       tick;
    logic       roll;
    logic [3:0] nbits;
    logic       wr_go;
    logic [4:0] wsel;
    logic [4:0] rsel;
    logic       wr_buf;
    logic       vote;
    logic       rx_samp;
    logic       decide;
    logic       rx_m1;
    logic [9:0] rx_new;
    logic [7:0] rx_data;
    logic       rx_ninth;
    logic       addr_hit;
    logic       rx_fin;
    logic       load_ok;

    // One-hot register select, zero when unmapped
    function automatic logic [4:0] reg_sel(input logic [7:0] a);
        if (a == CTRL_OFS) begin
            return 5'h01;
        end else if (a == DATA_OFS) begin
            return 5'h02;
        end else if (a == STAT_OFS) begin
            return 5'h04;
        end else if (a == MASK_OFS) begin
            return 5'h08;
        end else if (a == ADDR_OFS) begin
            return 5'h10;
        end else begin
            return 5'h00;
        end
    endfunction : reg_sel

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : maj3

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction : rev8

    // Pin crosses in through three flops and a filter flop
    spm_pin_sync u_rx_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .pin_in      (rxd_in),
        .level_out   (pin)
    );

    assign m0_div  = q.rmp ? M0_DIV_FAST : M0_DIV_SLOW;
    assign m0_half = {1'b0, m0_div[3:1]};
    assign m0_wrap = q.m0_act && (q.m0_cnt == m0_div - 4'h1);
    assign m0_last = m0_wrap && (q.m0_bits == BYTE_BITS - 4'h1);
    // Sixteen ticks per bit in async modes
    assign tick = (q.mode == MODE_FIX11) ? (q.pdiv == 2'h0)
                : (timer_ovf_in && (q.rate_doubler_bit || q.ovf_half));
    assign roll     = tick && (q.tx_div == OVS_LAST);
    assign rx_m1    = (q.mode == MODE_ASYNC10);
    assign nbits    = rx_m1 ? FRAME10 : FRAME11;
    assign wr_go    = q.aw_got && q.w_got && !q.bvalid;
    assign wsel     = reg_sel(q.awaddr);
    assign rsel     = reg_sel(s_axi_araddr_in);
    assign wr_buf   = wr_go && wsel[1] && q.wstrb[0];
    assign vote     = maj3({q.rx_v[1:0], pin});
    assign rx_samp  = q.rx_act && tick && (q.rx_div >= VOTE_FIRST)
                      && (q.rx_div <= VOTE_LAST);
    assign decide   = q.rx_act && tick && (q.rx_div == VOTE_LAST);
    assign rx_new   = {vote, q.rx_sh[9:1]};
    assign rx_data  = rx_m1 ? rx_new[8:1] : rx_new[7:0];
    assign rx_ninth = rx_m1 ? rx_new[9] : rx_new[8];
    // Mask bits set to one are don't-care
    assign addr_hit = ((rx_data ^ q.own_addr) & ~q.addr_mask) == 8'h00;
    assign rx_fin   = decide && (q.rx_bits == nbits - 4'h1);
    assign load_ok  = rx_fin && !q.ri && (!q.rmp ||
                      (rx_m1 ? vote : (rx_ninth && addr_hit)));

    always_comb begin
        d = q;
        // Bus slave: address and data taken in either order
        if (s_axi_awvalid_in && q.awrdy) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && q.wrdy) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata_in;
            d.wstrb = s_axi_wstrb_in;
        end
        if (wr_go) begin
            d.bvalid = 1'b1;
            d.bresp  = (wsel == 5'h00) ? RESP_SLVERR : RESP_OKAY;
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            if (q.wstrb[0]) begin
                if (wsel[0]) begin
                    d.mode = {q.wdata[CTL_MODE_HI], q.wdata[CTL_MODE_LO]};
                    d.rmp  = q.wdata[CTL_RMP];
                    d.ren  = q.wdata[CTL_REN];
                    d.tb8  = q.wdata[CTL_TB8];
                end
                if (wsel[2]) begin
                    // Write one to clear; hardware sets below win
                    d.ri = q.ri & ~q.wdata[ST_RI];
                    d.ti = q.ti & ~q.wdata[ST_TI];
                    d.fe = q.fe & ~q.wdata[ST_FE];
                end
                if (wsel[3]) begin
                    d.imask = q.wdata[2:0];
                end
                if (wsel[4]) begin
                    d.own_addr = q.wdata[7:0];
                end
            end
            if (q.wstrb[1]) begin
                if (wsel[0]) begin
                    d.rate_doubler_bit = q.wdata[CTL_RATE_DOUBLER_BIT];
                end
                if (wsel[4]) begin
                    d.addr_mask = q.wdata[15:8];
                end
            end
        end
        if (q.bvalid && s_axi_bready_in) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_arvalid_in && q.arrdy) begin
            d.rvalid = 1'b1;
            d.rresp  = (rsel == 5'h00) ? RESP_SLVERR : RESP_OKAY;
            d.rdata  = 32'h0;
            if (rsel[0]) begin
                d.rdata[CTL_MODE_HI] = q.mode[1];
                d.rdata[CTL_MODE_LO] = q.mode[0];
                d.rdata[CTL_RMP]     = q.rmp;
                d.rdata[CTL_REN]     = q.ren;
                d.rdata[CTL_TB8]     = q.tb8;
                d.rdata[CTL_RB8]     = q.rb8;
                d.rdata[CTL_RATE_DOUBLER_BIT]    = q.rate_doubler_bit;
            end else if (rsel[1]) begin
                d.rdata[7:0] = q.rbuf;
            end else if (rsel[2]) begin
                d.rdata[ST_RI] = q.ri;
                d.rdata[ST_TI] = q.ti;
                d.rdata[ST_FE] = q.fe;
            end else if (rsel[3]) begin
                d.rdata[2:0] = q.imask;
            end else if (rsel[4]) begin
                d.rdata[15:0] = {q.addr_mask, q.own_addr};
            end
        end
        if (q.rvalid && s_axi_rready_in) begin
            d.rvalid = 1'b0;
        end

        // Rate dividers
        if ((q.pdiv == 2'h0) || (q.mode != MODE_FIX11)) begin
            d.pdiv = q.rate_doubler_bit ? M2_TICK_FAST : M2_TICK_SLOW;
        end else begin
            d.pdiv = q.pdiv - 2'h1;
        end
        if (timer_ovf_in) begin
            d.ovf_half = ~q.ovf_half;
        end
        if (tick) begin
            d.tx_div = q.tx_div + 4'h1;
        end
        d.rx_prev = pin;

        if (q.mode == MODE_SYNC) begin
            d.rx_act = 1'b0;
            d.tx_act = 1'b0;
            d.tx_pend = 1'b0;
            if (!q.m0_act) begin
                if (wr_buf) begin
                    d.m0_act  = 1'b1;
                    d.m0_rx   = 1'b0;
                    d.m0_cnt  = 4'h0;
                    d.m0_bits = 4'h0;
                    d.m0_sh   = q.wdata[7:0];
                end else if (q.ren && !q.ri) begin
                    d.m0_act  = 1'b1;
                    d.m0_rx   = 1'b1;
                    d.m0_cnt  = 4'h0;
                    d.m0_bits = 4'h0;
                end
            end else begin
                d.m0_cnt = m0_wrap ? 4'h0 : q.m0_cnt + 4'h1;
                if (m0_wrap) begin
                    d.m0_bits = q.m0_bits + 4'h1;
                    if (!q.m0_rx) begin
                        d.m0_sh = {1'b0, q.m0_sh[7:1]};
                    end
                end
                if (q.m0_rx && (q.m0_cnt == m0_half)) begin
                    d.m0_sh = {q.m0_sh[6:0], pin};
                end
                if (m0_last) begin
                    d.m0_act = 1'b0;
                    if (q.m0_rx) begin
                        d.ri   = 1'b1;
                        d.rbuf = rev8(q.m0_sh);
                    end else begin
                        d.ti = 1'b1;
                    end
                end
            end
            // Shift clock low for the first half of each bit
            d.txd   = !d.m0_act || (d.m0_cnt >= m0_half);
            d.dout  = d.m0_sh[0];
            d.doe_n = !(d.m0_act && !d.m0_rx);
        end else begin
            d.m0_act = 1'b0;
            d.dout   = LINE_IDLE;
            d.doe_n  = 1'b1;
            // Bits start on counter rollover, not on the write
            if (wr_buf) begin
                d.tx_pend = 1'b1;
                d.tx_act  = 1'b0;
                d.tx_bits = 4'h0;
                d.tx_fr   = {1'b1, rx_m1 ? 1'b1 : q.tb8,
                             q.wdata[7:0], 1'b0};
            end else if (roll && (q.tx_pend || q.tx_act)) begin
                if (q.tx_bits == nbits) begin
                    d.tx_act = 1'b0;
                    d.txd    = LINE_IDLE;
                end else begin
                    d.tx_pend = 1'b0;
                    d.tx_act  = 1'b1;
                    d.txd     = q.tx_fr[0];
                    d.tx_fr   = {1'b1, q.tx_fr[10:1]};
                    d.tx_bits = q.tx_bits + 4'h1;
                    if (q.tx_bits == nbits - 4'h1) begin
                        d.ti = 1'b1;
                    end
                end
            end
            if (!q.rx_act) begin
                if (q.ren && !q.ri && q.rx_prev && !pin) begin
                    d.rx_act  = 1'b1;
                    d.rx_div  = 4'h0;
                    d.rx_bits = 4'h0;
                end
            end else if (tick) begin
                d.rx_div = q.rx_div + 4'h1;
                if (rx_samp) begin
                    d.rx_v = {q.rx_v[1:0], pin};
                end
                if (decide) begin
                    d.rx_bits = q.rx_bits + 4'h1;
                    if (q.rx_bits == 4'h0) begin
                        // False start bit: back to idle hunt
                        if (vote) begin
                            d.rx_act = 1'b0;
                        end
                    end else begin
                        d.rx_sh = rx_new;
                    end
                    if (rx_fin) begin
                        d.rx_act = 1'b0;
                        if (!vote) begin
                            d.fe = 1'b1;
                        end
                        if (load_ok) begin
                            d.rbuf = rx_data;
                            d.rb8  = rx_ninth;
                            d.ri   = 1'b1;
                        end
                    end
                end
            end
        end

        d.irq   = |({d.fe, d.ti, d.ri} & d.imask);
        d.awrdy = !d.aw_got && !d.bvalid;
        d.wrdy  = !d.w_got && !d.bvalid;
        d.arrdy = !d.rvalid;
        if (rst_in) begin
            d         = '0;
            d.txd     = LINE_IDLE;
            d.dout    = LINE_IDLE;
            d.doe_n   = 1'b1;
            d.rx_prev = LINE_IDLE;
        end
    end

    always_ff @(posedge core_clk_in) begin
        q <= d;
    end

    assign txd_out           = q.txd;
    assign rxd_out           = q.dout;
    assign rxd_oe_n_out      = q.doe_n;
    assign irq_out           = q.irq;
    assign s_axi_awready_out = q.awrdy;
    assign s_axi_wready_out  = q.wrdy;
    assign s_axi_bvalid_out  = q.bvalid;
    assign s_axi_bresp_out   = q.bresp;
    assign s_axi_arready_out = q.arrdy;
    assign s_axi_rvalid_out  = q.rvalid;
    assign s_axi_rdata_out   = q.rdata;
    assign s_axi_rresp_out   = q.rresp;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    m0_start_a: assert property (
        (wr_buf && q.mode == MODE_SYNC && !q.m0_act)
        |=> (q.m0_act && !q.m0_rx))
        else $error("mode 0 send not started");
    m0_rate_a: assert property (
        (q.mode == MODE_SYNC && !q.rmp && q.m0_act && $fell(q.txd))
        |-> (!q.txd) [*6] ##1 q.txd)
        else $error("mode 0 slow clock low phase wrong");
    m0_shift_a: assert property (
        (m0_wrap && !m0_last && !q.m0_rx)
        |=> (q.m0_sh == ($past(q.m0_sh) >> 1)))
        else $error("mode 0 send shift wrong");
    m0_tx_done_a: assert property (
        (m0_last && !q.m0_rx) |=> (!q.m0_act && q.ti))
        else $error("mode 0 send end wrong");
    m0_rx_samp_a: assert property (
        (q.m0_act && q.m0_rx && $rose(q.txd))
        |=> (q.m0_sh[0] == $past(pin)))
        else $error("mode 0 sample missed");
    m0_rx_done_a: assert property (
        (m0_last && q.m0_rx) |=> (q.ri && !q.m0_act))
        else $error("mode 0 receive end wrong");
    rx_start_a: assert property (
        $rose(q.rx_act) |-> ($past(q.ren) && !$past(q.ri)))
        else $error("receive started while gated");
    rx_abort_a: assert property (
        (decide && q.rx_bits == 4'h0 && vote) |=> !q.rx_act)
        else $error("false start not aborted");
    rx_load_a: assert property (
        ($rose(q.ri) && q.mode == MODE_ASYNC10) |-> $past(load_ok))
        else $error("mode 1 load without conditions");
    fe_set_a: assert property (
        (rx_fin && !vote) |=> q.fe)
        else $error("framing error not flagged");
    m2_rate_a: assert property (
        (tick && q.mode == MODE_FIX11 && !q.rate_doubler_bit)
        |=> (!tick) [*3] ##1 tick)
        else $error("mode 2 slow tick spacing wrong");
    ovf_rate_a: assert property (
        (tick && q.mode[0] && !q.rate_doubler_bit) |-> (timer_ovf_in && q.ovf_half))
        else $error("timer tick not halved");

    m0_rx_c: cover property (m0_last && q.m0_rx);
    rx_load_c: cover property (load_ok && q.mode == MODE_FIX11);
    fe_c: cover property (rx_fin && !vote);
    tx_end_c: cover property (roll && q.tx_act && q.tx_bits == nbits);

endmodule : spm_top

// >>> hw/spm_pkg.sv
// Purpose: Shared constants for the serial port block
// Assumes: 32-bit AXI4-Lite register bus, byte offsets below
// Notes:   Bit positions refer to the register data word
package spm_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DATA_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] MASK_OFS = 8'h0c;
    localparam logic [7:0] ADDR_OFS = 8'h10;

    // Control register fields
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_RMP     = 5;
    localparam int CTL_REN     = 4;
    localparam int CTL_TB8     = 3;
    localparam int CTL_RB8     = 2;
    localparam int CTL_RATE_DOUBLER_BIT    = 8;

    // Status and mask fields
    localparam int ST_RI = 0;
    localparam int ST_TI = 1;
    localparam int ST_FE = 2;

    // Operating modes
    localparam logic [1:0] MODE_SYNC    = 2'h0;
    localparam logic [1:0] MODE_ASYNC10 = 2'h1;
    localparam logic [1:0] MODE_FIX11   = 2'h2;

    // Cycle counts
    localparam logic [3:0] M0_DIV_SLOW = 4'hc;
    localparam logic [3:0] M0_DIV_FAST = 4'h4;
    localparam logic [1:0] M2_TICK_SLOW = 2'h3;
    localparam logic [1:0] M2_TICK_FAST = 2'h1;
    localparam logic [3:0] OVS_LAST    = 4'hf;
    localparam logic [3:0] VOTE_FIRST  = 4'h7;
    localparam logic [3:0] VOTE_LAST   = 4'h9;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] FRAME10     = 4'ha;
    localparam logic [3:0] FRAME11     = 4'hb;

    // Bus answers and line idle level
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic       LINE_IDLE   = 1'h1;

endpackage : spm_pkg

// >>> hw/spm_pin_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input idles high
// Notes:   Level updates only when stages two and three agree
`timescale 1ns/1ps
module spm_pin_sync
    import spm_pkg::*;
(
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } spm_sync_s;

    spm_sync_s q;
    spm_sync_s d;

    always_comb begin
        d    = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
        if (rst_in) begin
            d = {4{LINE_IDLE}};
        end
    end

    always_ff @(posedge core_clk_in) begin
        q <= d;
    end

    assign level_out = q.lvl;

endmodule : spm_pin_sync

// >>> tb/spm_shift_dev.sv
// Purpose: External 8-bit shift register on the mode 0 link
// Assumes: Shift clock and data pin seen on the core clock
// Notes:   Shifts out on clock rise, after the port has sampled
`timescale 1ns/1ps
module spm_shift_dev (
    input  wire logic       core_clk_in,
    input  wire logic       shclk_in,
    input  wire logic       data_in,
    input  wire logic       oe_n_in,
    input  wire logic       load_in,
    input  wire logic [7:0] load_val_in,
    output logic            data_out,
    output logic [7:0]      cap_out
);
    logic       clk_q;
    logic [7:0] out_q;
    always_ff @(posedge core_clk_in) begin
        clk_q <= shclk_in;
        if (load_in) begin
            out_q <= load_val_in;
        end else if (shclk_in && !clk_q && oe_n_in) begin
            out_q <= {1'h1, out_q[7:1]};
        end
        if (shclk_in && !clk_q && !oe_n_in) begin
            cap_out <= {data_in, cap_out[7:1]};
        end
    end
    // Ones refill, so a drained register reads like a pulled-up pin
    assign data_out = out_q[0];
endmodule : spm_shift_dev

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the four-mode serial port
// Assumes: Register offsets and fields from spm_pkg
// Notes:   Async receive is driven by the bench in place of a far UART
`timescale 1ns/1ps
module testbench
    import spm_pkg::*;
;
    logic        clk = 0, rst = 1, ovf = 0, awv = 0, wv = 0, bre = 0;
    logic        arv = 0, rre = 0, ld = 0, a_drv = 0, a_val = 1;
    logic [7:0]  awa = 0, ara = 0, ld_val = 0, cap;
    logic [31:0] wd = 0, rd_d, rdat;
    logic [1:0]  bresp, rd_r, rr, wb;
    logic        awr, wr_r, bv, arr, rv, rxd_o, oe_n, txd, irq, dev_o, rxd;
    int          bad_count = 0, total_checks = 0, cyc = 0;

    // Pin level: bench, then port when enabled, else the shift register
    assign rxd = a_drv ? a_val : (oe_n ? dev_o : rxd_o);

    spm_top u_spm_top (.core_clk_in(clk), .rst_in(rst), .timer_ovf_in(ovf),
        .rxd_in(rxd), .rxd_out(rxd_o), .rxd_oe_n_out(oe_n), .txd_out(txd),
        .irq_out(irq), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bre), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
        .s_axi_rdata_out(rd_d), .s_axi_rresp_out(rd_r));

    spm_shift_dev u_spm_shift_dev (.core_clk_in(clk), .shclk_in(txd),
        .data_in(rxd), .oe_n_in(oe_n), .load_in(ld), .load_val_in(ld_val),
        .data_out(dev_o), .cap_out(cap));

    initial forever #2.5 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        ovf <= (cyc % 4 == 0);
        if (cyc == 30000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd  <= d;
        awv <= 1;
        wv  <= 1;
        bre <= 1;
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr_r) wv <= 0;
        end while (!bv);
        wb = bresp;
        bre <= 0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rre <= 1;
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
        end while (!rv);
        rdat = rd_d;
        rr   = rd_r;
        rre <= 0;
    endtask : rd

    task automatic wait_irq();
        int n;
        for (n = 0; n < 3000 && irq !== 1'b1; n++) @(negedge clk);
        chk("irq", 1, irq);
    endtask : wait_irq

    task automatic t_reset();
        rd(CTRL_OFS);
        chk("ctrl reset", 0, rdat);
        chk("mapped resp", RESP_OKAY, rr);
        wr(8'h14, 32'h1);
        chk("unmapped wresp", RESP_SLVERR, wb);
        rd(8'h14);
        chk("unmapped resp", RESP_SLVERR, rr);
        chk("unmapped data", 0, rdat);
    endtask : t_reset

    task automatic t_m0_send(input logic fast);
        int n;
        wr(MASK_OFS, 32'h2);
        wr(CTRL_OFS, {26'h0, fast, 5'h0});
        wr(DATA_OFS, 32'ha5);
        @(negedge clk);
        chk("shift clock low", 0, txd);
        for (n = 0; n < 20 && txd === 1'b0; n++) @(negedge clk);
        // First low cycle has passed before the write returns
        chk("low half", (fast ? M0_DIV_FAST : M0_DIV_SLOW) / 2 - 1, n);
        wait_irq();
        chk("sent byte", 8'ha5, cap);
        rd(STAT_OFS);
        chk("status send", 32'h2, rdat);
        wr(STAT_OFS, 32'h2);
        rd(STAT_OFS);
        chk("status clear", 0, rdat);
        chk("irq clear", 0, irq);
    endtask : t_m0_send

    task automatic t_m0_recv();
        int n;
        @(posedge clk);
        ld     <= 1;
        ld_val <= 8'h3c;
        @(posedge clk);
        ld <= 0;
        wr(MASK_OFS, 32'h1);
        wr(CTRL_OFS, 32'h10);
        wait_irq();
        rd(DATA_OFS);
        chk("received byte", 8'h3c, rdat);
        for (n = 0; n < 40 && txd === 1'b1; n++) @(negedge clk);
        chk("no restart", 40, n);
        wr(CTRL_OFS, 0);
        wr(STAT_OFS, 32'h1);
    endtask : t_m0_recv

    task automatic t_m2_send();
        int n;
        logic [10:0] fr;
        wr(MASK_OFS, 32'h2);
        wr(CTRL_OFS, 32'h88);
        wr(DATA_OFS, 32'h5a);
        for (n = 0; n < 2000 && txd === 1'b1; n++) @(negedge clk);
        repeat (32) @(negedge clk);
        for (n = 0; n < 11; n++) begin
            fr[n] = txd;
            repeat (64) @(negedge clk);
        end
        chk("mode 2 frame", 11'h6b4, fr);
        wr(STAT_OFS, 32'h2);
    endtask : t_m2_send

    // Far sender: bt clocks a bit, then two idle bit times
    task automatic rx_frame(input logic [10:0] fr, input int bt);
        int n;
        a_drv <= 1;
        for (n = 0; n < 11; n++) begin
            a_val <= fr[n];
            repeat (bt) @(posedge clk);
        end
        a_val <= 1;
        repeat (2 * bt) @(posedge clk);
    endtask : rx_frame

    task automatic t_m2_recv();
        wr(CTRL_OFS, 32'h190);
        // Short low pulse must be dropped as a false start
        a_drv <= 1;
        a_val <= 0;
        repeat (6) @(posedge clk);
        a_val <= 1;
        repeat (400) @(posedge clk);
        rd(STAT_OFS);
        chk("false start", 0, rdat);
        rx_frame(11'h72c, 32);
        rd(DATA_OFS);
        chk("async byte", 8'h96, rdat);
        rd(CTRL_OFS);
        chk("ninth bit", 1, rdat[CTL_RB8]);
        wr(STAT_OFS, 32'h7);
        rx_frame(11'h32c, 32);
        rd(STAT_OFS);
        chk("framing error", 1, rdat[ST_FE]);
        wr(STAT_OFS, 32'h7);
    endtask : t_m2_recv

    // Doubler clear halves the timer pulses: mode 1 at 128 clocks a bit; mode 3, doubler set, at 64
    task automatic t_m1_m3_recv();
        wr(CTRL_OFS, 32'h70);
        rx_frame(11'h4aa, 128);
        rd(STAT_OFS);
        chk("stop gated", 32'h4, rdat);
        wr(STAT_OFS, 32'h7);
        rx_frame(11'h6aa, 128);
        rd(DATA_OFS);
        chk("mode 1 byte", 8'h55, rdat);
        wr(STAT_OFS, 32'h7);
        wr(ADDR_OFS, 32'h0fa0);
        wr(CTRL_OFS, 32'h1f0);
        rx_frame(11'h74a, 64);
        rd(DATA_OFS);
        chk("address hit", 8'ha5, rdat);
    endtask : t_m1_m3_recv

    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        t_reset();
        t_m0_send(0);
        t_m0_send(1);
        t_m0_recv();
        t_m2_send();
        t_m2_recv();
        t_m1_m3_recv();
        test_done();
    end
endmodule : testbench
